// file: test/sep_properties.sv
/*
  Checker for the link between host and memory ends, on ref_clk.
  Assumes tb_top instantiates it beside the host-to-memory link.
*/
`timescale 1ns/1ns
module sep_properties (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cs,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic busy
);
  logic [7:0] low_cnt;
  logic [7:0] next_low_cnt;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // saturates so a long idle cannot wrap and look short
  assign next_low_cnt = cs ? 8'h00 :
    (low_cnt == 8'hFF) ? low_cnt : low_cnt + 8'h01;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) low_cnt <= 8'h00;
    else low_cnt <= next_low_cnt;
  end

  chk_deselect_gap: assert property (
    $rose(cs) |-> low_cnt >= 8'h20) else $error("select gap too short");
  chk_start_bit: assert property (
    $rose(cs) |-> serial_in && !sclk) else $error("frame lacks start bit");
  chk_clock_parked: assert property (
    !cs [*2] |-> !sclk) else $error("clock runs while deselected");
  chk_high_time: assert property (
    $rose(sclk) |-> sclk [*5]) else $error("clock high too short");
  chk_low_time: assert property (
    $fell(sclk) |-> !sclk [*5]) else $error("clock low too short");
  chk_release_desel: assert property (
    $fell(cs) |-> ##[1:8] !so_oe) else $error("output not released");
  chk_idle_released: assert property (
    !cs [*8] |-> !so_oe) else $error("output driven while deselected");
  chk_busy_status: assert property (
    (busy && cs) [*8] |-> so_oe && !so_out) else $error("busy not shown");
  chk_ready_status: assert property (
    $fell(busy) ##0 cs |-> ##[1:12] (so_oe && so_out))
    else $error("ready not shown");
  chk_busy_no_clock: assert property (
    busy [*8] |-> !sclk && cs) else $error("clock during programming");

  cov_prog_done: cover property ($fell(busy));
  cov_out_driven: cover property ($rose(so_oe));
  cov_frame: cover property ($rose(cs));
endmodule : sep_properties

// file: test/tb_top.sv
/*
  Self-checking bench: host and memory ends on one link, and a second
  memory end driven directly with an enable frame, an aborted write frame and a complete write frame.
  Assumes the design files under verilog/ are compiled first.
*/
`timescale 1ns/1ns
module tb_top;
  localparam int PROG = 3000;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  sep_pkg::sep_op_t cmd_op = sep_pkg::sep_read;
  logic [10:0] cmd_addr = 11'h000;
  logic [15:0] cmd_data = 16'h0000;
  logic cmd_wide = 1'b1;
  logic rd_valid;
  logic rd_ready = 1'b0;
  logic [15:0] rd_data;
  logic strap = 1'b1;
  logic permit = 1'b1;
  logic busy;
  logic busy_b;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;

  sep_if lnk ();
  sep_if lnk_b ();

  sep_host i_sep_host (.ref_clk(ref_clk), .rst_b(rst_b), .lnk(lnk.host),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_wide(cmd_wide),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
  sep_dev #(.PROG_CYCLES(PROG)) i_sep_dev (.ref_clk(ref_clk),
    .rst_b(rst_b), .lnk(lnk.dev), .word_width_strap(strap),
    .write_permit_pin(permit), .busy(busy));
  sep_dev #(.PROG_CYCLES(PROG)) i_sep_dev_b (.ref_clk(ref_clk),
    .rst_b(rst_b), .lnk(lnk_b.dev), .word_width_strap(1'b1),
    .write_permit_pin(1'b1), .busy(busy_b));
  sep_properties i_sep_properties (.ref_clk(ref_clk), .rst_b(rst_b),
    .cs(lnk.cs), .sclk(lnk.sclk), .serial_in(lnk.serial_in),
    .so_out(lnk.so_out), .so_oe(lnk.so_oe), .busy(busy));

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  // generous ceiling: twenty programming cycles' worth of ref_clk, frames included
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk_word(input string name, input logic [15:0] exp,
      input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string name, input logic exp,
      input logic got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task automatic do_cmd(input sep_pkg::sep_op_t op, input logic [10:0] a,
      input logic [15:0] d);
    @(negedge ref_clk);
    while (cmd_ready !== 1'b1) @(negedge ref_clk);
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
  endtask : do_cmd

  task automatic pop_chk(input logic [15:0] exp);
    while (rd_valid !== 1'b1) @(negedge ref_clk);
    chk_word("rd_data", exp, rd_data);
    rd_ready = 1'b1;
    @(negedge ref_clk);
    rd_ready = 1'b0;
  endtask : pop_chk

  task automatic rd_word(input logic [10:0] a, input logic [15:0] exp);
    do_cmd(sep_pkg::sep_read, a, 16'h0000);
    pop_chk(exp);
  endtask : rd_word

  task automatic s_write_read;
    do_cmd(sep_pkg::sep_ewen, 11'h000, 16'h0000);
    do_cmd(sep_pkg::sep_write, 11'h2A5, 16'h1234);
    rd_word(11'h2A5, 16'h1234);
    do_cmd(sep_pkg::sep_erase, 11'h2A5, 16'h0000);
    rd_word(11'h2A5, 16'hFFFF);
  endtask : s_write_read

  task automatic s_all;
    do_cmd(sep_pkg::sep_wral, 11'h000, 16'h5A0F);
    rd_word(11'h000, 16'h5A0F);
    rd_word(11'h3FF, 16'h5A0F);
    do_cmd(sep_pkg::sep_eral, 11'h000, 16'h0000);
    rd_word(11'h155, 16'hFFFF);
  endtask : s_all

  task automatic s_protect;
    permit = 1'b0;
    do_cmd(sep_pkg::sep_write, 11'h155, 16'h0000);
    rd_word(11'h155, 16'hFFFF);
    permit = 1'b1;
  endtask : s_protect

  // receiver stalls: two words wait, the third read holds the link
  task automatic s_buffer;
    do_cmd(sep_pkg::sep_write, 11'h001, 16'h1111);
    do_cmd(sep_pkg::sep_write, 11'h002, 16'h2222);
    do_cmd(sep_pkg::sep_write, 11'h003, 16'h3333);
    do_cmd(sep_pkg::sep_read, 11'h001, 16'h0000);
    do_cmd(sep_pkg::sep_read, 11'h002, 16'h0000);
    do_cmd(sep_pkg::sep_read, 11'h003, 16'h0000);
    repeat (300) @(negedge ref_clk);
    chk_bit("cmd_ready", 1'b0, cmd_ready);
    chk_bit("rd_valid", 1'b1, rd_valid);
    chk_bit("cs", 1'b1, lnk.cs);
    pop_chk(16'h1111);
    pop_chk(16'h2222);
    pop_chk(16'h3333);
  endtask : s_buffer

  task automatic bit_b(input logic v);
    lnk_b.serial_in = v;
    repeat (5) @(negedge ref_clk);
    lnk_b.sclk = 1'b1;
    repeat (5) @(negedge ref_clk);
    lnk_b.sclk = 1'b0;
  endtask : bit_b

  task automatic frame_b(input logic [31:0] v, input int n);
    lnk_b.cs = 1'b1;
    for (int i = n - 1; i >= 0; i--) bit_b(v[i]);
    lnk_b.cs = 1'b0;
    // released data line must not keep a stale level
    lnk_b.serial_in = ~lnk_b.serial_in;
    repeat (40) @(negedge ref_clk);
  endtask : frame_b

  task automatic s_link_b;
    frame_b(32'h0000_1300, 16);
    frame_b(32'h0000_1405, 13);
    chk_bit("busy_b", 1'b0, busy_b);
    frame_b({3'b000, 1'b1, 2'b01, 10'h005, 16'hBEEF}, 29);
    chk_bit("busy_b", 1'b1, busy_b);
    chk_bit("so_oe_b", 1'b0, lnk_b.so_oe);
    repeat (PROG - 100) @(negedge ref_clk);
    chk_bit("busy_b", 1'b1, busy_b);
    repeat (200) @(negedge ref_clk);
    chk_bit("busy_b", 1'b0, busy_b);
  endtask : s_link_b

  task automatic s_x8;
    strap = 1'b0;
    cmd_wide = 1'b0;
    rst_b = 1'b0;
    repeat (16) @(negedge ref_clk);
    rst_b = 1'b1;
    do_cmd(sep_pkg::sep_ewen, 11'h000, 16'h0000);
    do_cmd(sep_pkg::sep_write, 11'h7FF, 16'h00C6);
    rd_word(11'h7FF, 16'h00C6);
  endtask : s_x8

  initial begin
    lnk_b.cs = 1'b0;
    lnk_b.sclk = 1'b0;
    lnk_b.serial_in = 1'b0;
    repeat (16) @(negedge ref_clk);
    rst_b = 1'b1;
    s_write_read();
    s_all();
    s_protect();
    s_buffer();
    s_link_b();
    s_x8();
    close_out();
  end
endmodule : tb_top

// file: verilog/sep_cfg.svh
/*
  Constants for the serial EEPROM pin interface: frame layout, opcode
  encodings, array size and timing counts. Assumes a 125 MHz reference
  clock on both ends and a host that generates the serial clock.
*/
`ifndef SEP_CFG_SVH
`define SEP_CFG_SVH

`define SEP_HDR_BITS 5'h3
`define SEP_AW16 5'hA
`define SEP_AW8 5'hB
`define SEP_DW16 5'h10
`define SEP_DW8 5'h08
`define SEP_FRAME_W 30
`define SEP_MEM_BYTES 2048

`define SEP_OPC_EXT 2'h0
`define SEP_OPC_WRITE 2'h1
`define SEP_OPC_READ 2'h2
`define SEP_OPC_ERASE 2'h3
`define SEP_SUB_EWDS 2'h0
`define SEP_SUB_WRAL 2'h1
`define SEP_SUB_ERAL 2'h2
`define SEP_SUB_EWEN 2'h3

`define SEP_REF_MHZ 125
`define SEP_REF_NS 8
`define SEP_PROG_TIME_US 3000
`define SEP_PROG_CYCLES (`SEP_PROG_TIME_US * `SEP_REF_MHZ)
`define SEP_DESEL_MIN_NS 250
`define SEP_DESEL_CYCLES ((`SEP_DESEL_MIN_NS + `SEP_REF_NS - 1) / `SEP_REF_NS)
`define SEP_HALF_CYCLES 5
`define SEP_POLL_SETTLE 8

`endif

// file: verilog/sep_dev.sv
/*
  Memory device end: serial decoder on the link clock, self-timed
  programming engine and output driver on ref_clk, byte array.
  Assumes the host keeps the link protocol; strap and permit are static.
*/
`timescale 1ns/1ns
`include "sep_cfg.svh"
module sep_dev #(
  parameter int PROG_CYCLES = `SEP_PROG_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  sep_if.dev lnk,
  input wire logic word_width_strap,
  input wire logic write_permit_pin,
  output logic busy
);
  logic [7:0] mem [0:`SEP_MEM_BYTES-1];

  // decoder reset: select low clears it whatever the clock does
  wire link_rst_b = rst_b & lnk.cs;

  logic [2:0] strap_q;
  logic wide;
  always_ff @(posedge lnk.sclk or negedge rst_b) begin
    if (!rst_b) begin
      strap_q <= 3'h7;
      wide <= 1'b1;
    end else begin
      strap_q <= {strap_q[1:0], word_width_strap};
      if (strap_q[1] == strap_q[2]) begin
        wide <= strap_q[2];
      end
    end
  end

  sep_pkg::sep_dst_t st;
  logic [4:0] cnt;
  logic [1:0] opc;
  logic [10:0] addr;
  logic [15:0] data;
  logic [15:0] rd_sh;
  logic rd_bit;
  logic rd_mode;
  logic st_mode;

  wire si = lnk.serial_in;
  wire [10:0] next_addr = {addr[9:0], si};
  wire [15:0] next_data = {data[14:0], si};
  wire [10:0] a_sel = (st == sep_pkg::sep_d_data) ? addr : next_addr;
  wire [4:0] addr_last = wide ? `SEP_AW16 - 5'h1 : `SEP_AW8 - 5'h1;
  wire [4:0] data_last = wide ? `SEP_DW16 - 5'h1 : `SEP_DW8 - 5'h1;
  wire [1:0] sub = wide ? a_sel[9:8] : a_sel[10:9];
  wire is_ext = opc == `SEP_OPC_EXT;
  wire is_read = opc == `SEP_OPC_READ;
  wire needs_data = (opc == `SEP_OPC_WRITE) ||
                    (is_ext && sub == `SEP_SUB_WRAL);
  wire programs = !is_ext || sub == `SEP_SUB_ERAL || sub == `SEP_SUB_WRAL;
  wire addr_end = (st == sep_pkg::sep_d_addr) && (cnt == addr_last);
  wire data_end = (st == sep_pkg::sep_d_data) && (cnt == data_last);
  // only a fully clocked instruction is handed to the engine
  wire issue = (addr_end && !is_read && !needs_data) || data_end;

  // array read for the word being addressed or the next sequential one
  wire [10:0] rd_a = (st == sep_pkg::sep_d_read) ? addr + 11'h1 : next_addr;
  wire [15:0] rd_word = wide ?
    {mem[{rd_a[9:0], 1'b0}], mem[{rd_a[9:0], 1'b1}]} : {mem[rd_a], 8'h00};

  sep_pkg::sep_op_t issue_op;
  assign issue_op = !is_ext ?
    ((opc == `SEP_OPC_WRITE) ? sep_pkg::sep_write : sep_pkg::sep_erase) :
    (sub == `SEP_SUB_EWEN) ? sep_pkg::sep_ewen :
    (sub == `SEP_SUB_EWDS) ? sep_pkg::sep_ewds :
    (sub == `SEP_SUB_ERAL) ? sep_pkg::sep_eral : sep_pkg::sep_wral;

  // state only advances on an edge, so a paused clock keeps everything
  always_ff @(posedge lnk.sclk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      st <= sep_pkg::sep_d_wait;
      cnt <= 5'h00;
      opc <= 2'h0;
      addr <= 11'h000;
      data <= 16'h0000;
      rd_sh <= 16'h0000;
      rd_bit <= 1'b0;
      rd_mode <= 1'b0;
      st_mode <= 1'b0;
    end else begin
      case (st)
        sep_pkg::sep_d_wait: begin
          if (si) begin
            st <= sep_pkg::sep_d_opc;
          end
        end
        sep_pkg::sep_d_opc: begin
          opc <= {opc[0], si};
          cnt <= cnt + 5'h01;
          if (cnt == 5'h01) begin
            cnt <= 5'h00;
            st <= sep_pkg::sep_d_addr;
          end
        end
        sep_pkg::sep_d_addr: begin
          addr <= next_addr;
          cnt <= cnt + 5'h01;
          if (addr_end) begin
            cnt <= 5'h00;
            if (is_read) begin
              st <= sep_pkg::sep_d_read;
              rd_mode <= 1'b1;
              rd_bit <= 1'b0;
              rd_sh <= rd_word;
            end else if (needs_data) begin
              st <= sep_pkg::sep_d_data;
            end else begin
              st <= sep_pkg::sep_d_done;
              st_mode <= programs;
            end
          end
        end
        sep_pkg::sep_d_data: begin
          data <= next_data;
          cnt <= cnt + 5'h01;
          if (data_end) begin
            st <= sep_pkg::sep_d_done;
            st_mode <= 1'b1;
          end
        end
        sep_pkg::sep_d_read: begin
          rd_bit <= rd_sh[15];
          rd_sh <= {rd_sh[14:0], 1'b0};
          cnt <= cnt + 5'h01;
          if (cnt == data_last) begin
            cnt <= 5'h00;
            addr <= addr + 11'h001;
            rd_sh <= rd_word;
          end
        end
        sep_pkg::sep_d_done: begin
          st <= sep_pkg::sep_d_done;
        end
        default: begin
          st <= sep_pkg::sep_d_wait;
        end
      endcase
    end
  end

  // command hand-off survives deselect; the toggle marks a new one
  logic req_tgl;
  sep_pkg::sep_op_t cmd_op;
  logic [10:0] cmd_addr;
  logic [15:0] cmd_data;
  logic cmd_wide;
  always_ff @(posedge lnk.sclk or negedge rst_b) begin
    if (!rst_b) begin
      req_tgl <= 1'b0;
      cmd_op <= sep_pkg::sep_ewds;
      cmd_addr <= 11'h000;
      cmd_data <= 16'h0000;
      cmd_wide <= 1'b1;
    end else if (issue && link_rst_b) begin
      req_tgl <= ~req_tgl;
      cmd_op <= issue_op;
      cmd_addr <= a_sel;
      cmd_data <= next_data;
      cmd_wide <= wide;
    end
  end

  // three-stage filters into ref_clk: bits count once stages 2 and 3 agree
  logic [5:0] sy1;
  logic [5:0] sy2;
  logic [5:0] sy3;
  logic [5:0] syf;
  wire [5:0] sy_in = {write_permit_pin, lnk.cs, rd_mode, rd_bit, st_mode,
                      req_tgl};
  wire [5:0] agree = ~(sy2 ^ sy3);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sy1 <= 6'h20;
      sy2 <= 6'h20;
      sy3 <= 6'h20;
      syf <= 6'h20;
    end else begin
      sy1 <= sy_in;
      sy2 <= sy1;
      sy3 <= sy2;
      syf <= (sy3 & agree) | (syf & ~agree);
    end
  end
  wire permit_f = syf[5];
  wire cs_f = syf[4];
  wire rdm_f = syf[3];
  wire rdb_f = syf[2];
  wire stm_f = syf[1];
  wire tgl_f = syf[0];

  logic tgl_seen;
  logic ewen;
  logic sweeping;
  logic [31:0] timer;
  logic [10:0] ptr;
  logic [10:0] last;
  logic [7:0] pat_hi;
  logic [7:0] pat_lo;
  logic pat_wide;

  wire new_cmd = tgl_f != tgl_seen;
  wire prog_op = (cmd_op != sep_pkg::sep_ewen) && (cmd_op != sep_pkg::sep_ewds);
  wire all_op = (cmd_op == sep_pkg::sep_eral) || (cmd_op == sep_pkg::sep_wral);
  wire erase_op = (cmd_op == sep_pkg::sep_erase) ||
                  (cmd_op == sep_pkg::sep_eral);
  wire start = new_cmd && prog_op && ewen && permit_f && !busy;
  wire [10:0] w_base = cmd_wide ? {cmd_addr[9:0], 1'b0} : cmd_addr;
  wire [10:0] w_last = cmd_wide ? {cmd_addr[9:0], 1'b1} : cmd_addr;
  wire [7:0] wr_byte = (pat_wide && !ptr[0]) ? pat_hi : pat_lo;
  wire prog_done = (timer == 32'h00000000) && !sweeping;

  // engine on ref_clk: needs no serial clock and ignores select
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tgl_seen <= 1'b0;
      ewen <= 1'b0;
      busy <= 1'b0;
      sweeping <= 1'b0;
      timer <= 32'h00000000;
      ptr <= 11'h000;
      last <= 11'h000;
      pat_hi <= 8'hFF;
      pat_lo <= 8'hFF;
      pat_wide <= 1'b0;
    end else begin
      tgl_seen <= tgl_f;
      if (new_cmd && cmd_op == sep_pkg::sep_ewen) begin
        ewen <= 1'b1;
      end
      if (new_cmd && cmd_op == sep_pkg::sep_ewds) begin
        ewen <= 1'b0;
      end
      if (start) begin
        busy <= 1'b1;
        sweeping <= 1'b1;
        timer <= 32'(PROG_CYCLES - 1);
        ptr <= all_op ? 11'h000 : w_base;
        last <= all_op ? 11'(`SEP_MEM_BYTES - 1) : w_last;
        pat_hi <= erase_op ? 8'hFF : cmd_data[15:8];
        pat_lo <= erase_op ? 8'hFF : cmd_data[7:0];
        pat_wide <= cmd_wide;
      end else if (busy) begin
        if (timer != 32'h00000000) begin
          timer <= timer - 32'h00000001;
        end
        if (sweeping && ptr == last) begin
          sweeping <= 1'b0;
        end else if (sweeping) begin
          ptr <= ptr + 11'h001;
        end
        if (prog_done) begin
          busy <= 1'b0;
        end
      end
    end
  end

  // one byte per cycle; a full-array pass fits well inside the timer
  always_ff @(posedge ref_clk) begin
    if (sweeping) begin
      mem[ptr] <= wr_byte;
    end
  end

  // pending command counts as busy so status never flashes ready early
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lnk.so_oe <= 1'b0;
      lnk.so_out <= 1'b1;
    end else begin
      lnk.so_oe <= cs_f & (rdm_f | stm_f);
      lnk.so_out <= rdm_f ? rdb_f : !(busy | new_cmd);
    end
  end
endmodule : sep_dev

// file: verilog/sep_host.sv
/*
  Host end: takes one instruction at a time, makes the serial clock by
  dividing ref_clk, shifts the frame, collects read words into a
  two-entry buffer and polls status after programming.
  Assumes the device end of sep_if; the user keeps cmd_* stable while valid.
*/
`timescale 1ns/1ns
`include "sep_cfg.svh"
module sep_host (
  input wire logic ref_clk,
  input wire logic rst_b,
  sep_if.host lnk,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire sep_pkg::sep_op_t cmd_op,
  input wire logic [10:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  input wire logic cmd_wide,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [15:0] rd_data
);
  wire [1:0] h_opc = (cmd_op == sep_pkg::sep_read) ? `SEP_OPC_READ :
                     (cmd_op == sep_pkg::sep_write) ? `SEP_OPC_WRITE :
                     (cmd_op == sep_pkg::sep_erase) ? `SEP_OPC_ERASE :
                     `SEP_OPC_EXT;
  wire [1:0] h_sub = (cmd_op == sep_pkg::sep_ewen) ? `SEP_SUB_EWEN :
                     (cmd_op == sep_pkg::sep_ewds) ? `SEP_SUB_EWDS :
                     (cmd_op == sep_pkg::sep_eral) ? `SEP_SUB_ERAL :
                     `SEP_SUB_WRAL;
  wire h_ext = h_opc == `SEP_OPC_EXT;
  wire [10:0] ea = !h_ext ? cmd_addr :
                   cmd_wide ? {1'b0, h_sub, cmd_addr[7:0]} :
                   {h_sub, cmd_addr[8:0]};
  wire h_data = (cmd_op == sep_pkg::sep_write) || (cmd_op == sep_pkg::sep_wral);
  wire [`SEP_FRAME_W-1:0] frame_w = {1'b1, h_opc, ea[9:0], cmd_data, 1'b0};
  wire [`SEP_FRAME_W-1:0] frame_n = {1'b1, h_opc, ea, cmd_data[7:0], 8'h00};
  wire [4:0] nbits = `SEP_HDR_BITS + (cmd_wide ? `SEP_AW16 : `SEP_AW8) +
                     (h_data ? (cmd_wide ? `SEP_DW16 : `SEP_DW8) : 5'h00);

  // returning data: three stages, counts once stages 2 and 3 agree
  logic [2:0] dq;
  logic do_f;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dq <= 3'h7;
      do_f <= 1'b1;
    end else begin
      dq <= {dq[1:0], lnk.serial_out};
      if (dq[1] == dq[2]) begin
        do_f <= dq[2];
      end
    end
  end

  sep_pkg::sep_hst_t st;
  sep_pkg::sep_op_t opl;
  logic wl;
  logic [`SEP_FRAME_W-1:0] frame;
  logic [4:0] bits;
  logic [3:0] hc;
  logic [4:0] rcnt;
  logic [15:0] rword;
  logic [5:0] gapc;
  logic [3:0] pc;
  logic s_valid;
  logic [15:0] s_data;

  wire tick = hc == 4'h0;
  wire in_ready = !s_valid;
  wire push = (st == sep_pkg::sep_h_push) && in_ready;
  wire pop = rd_valid && rd_ready;
  wire [4:0] rd_last = wl ? `SEP_DW16 : `SEP_DW8;
  wire [5:0] gap_load = 6'(`SEP_DESEL_CYCLES - 1);
  wire [3:0] half_load = 4'(`SEP_HALF_CYCLES - 1);
  wire no_poll = (opl == sep_pkg::sep_ewen) || (opl == sep_pkg::sep_ewds);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= sep_pkg::sep_h_gap;
      opl <= sep_pkg::sep_read;
      wl <= 1'b1;
      frame <= '0;
      bits <= 5'h00;
      hc <= 4'h0;
      rcnt <= 5'h00;
      rword <= 16'h0000;
      // full gap after reset too: select was never seen low that long
      gapc <= 6'(`SEP_DESEL_CYCLES - 1);
      pc <= 4'h0;
      cmd_ready <= 1'b0;
      lnk.cs <= 1'b0;
      lnk.sclk <= 1'b0;
      lnk.serial_in <= 1'b0;
    end else begin
      hc <= tick ? half_load : hc - 4'h1;
      case (st)
        sep_pkg::sep_h_idle: begin
          hc <= half_load;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            lnk.cs <= 1'b1;
            lnk.serial_in <= 1'b1;
            frame <= cmd_wide ? frame_w : frame_n;
            bits <= nbits;
            opl <= cmd_op;
            wl <= cmd_wide;
            rcnt <= 5'h00;
            rword <= 16'h0000;
            st <= sep_pkg::sep_h_shift;
          end
        end
        sep_pkg::sep_h_shift: begin
          // data changes on the falling edge, sampled on the rising one
          if (tick && !lnk.sclk) begin
            lnk.sclk <= 1'b1;
          end else if (tick) begin
            lnk.sclk <= 1'b0;
            frame <= {frame[`SEP_FRAME_W-2:0], 1'b0};
            lnk.serial_in <= frame[`SEP_FRAME_W-2];
            bits <= bits - 5'h01;
            if (bits == 5'h01 && opl == sep_pkg::sep_read) begin
              st <= sep_pkg::sep_h_read;
            end else if (bits == 5'h01 && no_poll) begin
              lnk.cs <= 1'b0;
              gapc <= gap_load;
              st <= sep_pkg::sep_h_gap;
            end else if (bits == 5'h01) begin
              pc <= 4'(`SEP_POLL_SETTLE);
              st <= sep_pkg::sep_h_poll;
            end
          end
        end
        sep_pkg::sep_h_read: begin
          // sample late in the low phase: device output lags the edge
          if (tick && !lnk.sclk) begin
            rword <= {rword[14:0], do_f};
            if (rcnt == rd_last) begin
              st <= sep_pkg::sep_h_push;
            end else begin
              rcnt <= rcnt + 5'h01;
              lnk.sclk <= 1'b1;
            end
          end else if (tick) begin
            lnk.sclk <= 1'b0;
          end
        end
        sep_pkg::sep_h_push: begin
          // full buffer stalls here with the clock parked low
          if (in_ready) begin
            lnk.cs <= 1'b0;
            gapc <= gap_load;
            st <= sep_pkg::sep_h_gap;
          end
        end
        sep_pkg::sep_h_poll: begin
          if (pc != 4'h0) begin
            pc <= pc - 4'h1;
          end else if (do_f) begin
            lnk.cs <= 1'b0;
            gapc <= gap_load;
            st <= sep_pkg::sep_h_gap;
          end
        end
        sep_pkg::sep_h_gap: begin
          if (gapc == 6'h00) begin
            cmd_ready <= 1'b1;
            st <= sep_pkg::sep_h_idle;
          end else begin
            gapc <= gapc - 6'h01;
          end
        end
        default: begin
          st <= sep_pkg::sep_h_gap;
        end
      endcase
    end
  end

  // two-entry buffer: head drives the outputs, second entry catches a stall
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_valid <= 1'b0;
      rd_data <= 16'h0000;
      s_valid <= 1'b0;
      s_data <= 16'h0000;
    end else if (pop && s_valid) begin
      rd_data <= s_data;
      s_valid <= push;
      s_data <= rword;
    end else if (pop) begin
      rd_valid <= push;
      rd_data <= rword;
    end else if (push && !rd_valid) begin
      rd_valid <= 1'b1;
      rd_data <= rword;
    end else if (push) begin
      s_valid <= 1'b1;
      s_data <= rword;
    end
  end
endmodule : sep_host

// file: verilog/sep_if.sv
/*
  Three-wire link between host and memory device, plus the shared data
  output wire. Assumes the device only drives while so_oe is high; the
  idle wire level models a weak pull-up.
*/
`timescale 1ns/1ns
interface sep_if;
  logic cs;
  logic sclk;
  logic serial_in;
  logic so_out;
  logic so_oe;
  wire serial_out;

  assign serial_out = so_oe ? so_out : 1'b1;

  modport dev (
    input cs,
    input sclk,
    input serial_in,
    output so_out,
    output so_oe
  );
  modport host (
    output cs,
    output sclk,
    output serial_in,
    input serial_out
  );
endinterface : sep_if

// file: verilog/sep_pkg.sv
/*
  Types shared by both ends: instruction kinds and the state sets.
  Assumes sep_cfg.svh carries the numeric constants.
*/
package sep_pkg;
  typedef enum logic [2:0] {
    sep_read, sep_write, sep_erase, sep_ewen, sep_ewds, sep_eral, sep_wral
  } sep_op_t;
  typedef enum logic [2:0] {
    sep_d_wait, sep_d_opc, sep_d_addr, sep_d_data, sep_d_read, sep_d_done
  } sep_dst_t;
  typedef enum logic [2:0] {
    sep_h_idle, sep_h_shift, sep_h_read, sep_h_push, sep_h_poll, sep_h_gap
  } sep_hst_t;
endpackage : sep_pkg
